// ===== rtl/brwc_top.sv
// Purpose: Runs external bus cycles in five phases with READY-controlled access
// Assumes: Request inputs are synchronous to clk_i; ready_i may be asynchronous
// Notes: Configuration through classic Wishbone slave registers
`timescale 1ns/1ps
// Behaviour
// - Ready polarity is selectable by software
// - Asynchronous mode adds synchroniser stage, wait state
// - Inactive ready sample inserts one wait state
// - Active ready sample ends access phase
// - Sampling point differs by synchroniser latency
// - Read data captured on strobe rising edge
// - Late address change cannot disturb captured data
// - Every cycle runs five programmable phases
// - Only access phase extends via ready
module brwc_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Bus cycle request
   input wire logic req_valid_i,
   input wire brwc_pkg::brwc_req_t req_i,
   output logic req_ready_o,
   output logic done_o,
   output logic [15:0] rdata_o,
   // External bus pins
   output logic bus_reference_clock_out_o,
   output logic cs_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   output logic [23:0] addr_o,
   output logic [15:0] data_o,
   output logic data_oe_o,
   input wire logic [15:0] data_i,
   input wire logic ready_i
);
   logic [31:0] ctrl_q, ctrl_d, time_q, time_d;
   logic ack_q, ack_d;
   logic [31:0] rd_q, rd_d;
   brwc_pkg::brwc_phase_t ph;
   brwc_pkg::brwc_state_t st_q, st_d;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] wcnt_q, wcnt_d;
   // Request held for the whole cycle so pins stay put
   brwc_pkg::brwc_req_t cur_q, cur_d;
   logic [15:0] rdata_q, rdata_d;
   logic done_q, done_d;
   logic sync1_q, sync2_q, rdy_sync_q;
   logic rdy_level, rdy_act, pol, async_m, rdy_en;
   logic cs_n_q, cs_n_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d, oe_q, oe_d;

   assign ph = brwc_pkg::brwc_phase_t'({time_q[brwc_pkg::TM_AB_LSB +: 2],
      time_q[brwc_pkg::TM_C_LSB +: 2], time_q[brwc_pkg::TM_D_LSB],
      time_q[brwc_pkg::TM_E_LSB +: 5], time_q[brwc_pkg::TM_F_LSB +: 2]});
   assign pol = ctrl_q[brwc_pkg::CTRL_POL_BIT];
   assign async_m = ctrl_q[brwc_pkg::CTRL_ASYNC_BIT];
   assign rdy_en = ctrl_q[brwc_pkg::CTRL_RDYEN_BIT];

   // Register slave
   always_comb begin
      logic hit;
      hit = cyc_i && stb_i && !ack_q;
      ctrl_d = ctrl_q;
      time_d = time_q;
      rd_d = rd_q;
      ack_d = hit;
      if (hit && we_i && sel_i[0]) begin
         if (adr_i == brwc_pkg::ADR_CTRL) begin
            ctrl_d[7:0] = {5'h00, dat_i[2:0]};
         end
      end
      if (hit && we_i && adr_i == brwc_pkg::ADR_TIME) begin
         for (int b = 0; b < 4; b++) begin
            if (sel_i[b]) begin
               time_d[b*8 +: 8] = dat_i[b*8 +: 8] & brwc_pkg::TIME_MASK[b*8 +: 8];
            end
         end
      end
      if (hit && !we_i) begin
         unique case (adr_i)
            brwc_pkg::ADR_CTRL: rd_d = ctrl_q;
            brwc_pkg::ADR_TIME: rd_d = time_q;
            brwc_pkg::ADR_STAT: rd_d = {16'h0000, wcnt_q, 7'h00, st_q != brwc_pkg::BRWC_IDLE};
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= brwc_pkg::CTRL_RESET;
         time_q <= brwc_pkg::TIME_RESET;
         ack_q <= 1'b0;
         rd_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         time_q <= time_d;
         ack_q <= ack_d;
         rd_q <= rd_d;
      end
   end
   assign ack_o = ack_q;
   assign dat_o = rd_q;

   // Ready input path: sync stage only feeds the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         rdy_sync_q <= 1'b0;
      end else begin
         sync1_q <= ready_i;
         sync2_q <= sync1_q;
         rdy_sync_q <= ready_i;
      end
   end
   // Async path is one edge later than sync path
   assign rdy_level = async_m ? sync2_q : rdy_sync_q;
   assign rdy_act = rdy_level ~^ pol;

   // Bus cycle sequencer
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      wcnt_d = wcnt_q;
      cur_d = cur_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      cs_n_d = cs_n_q;
      rd_n_d = rd_n_q;
      wr_n_d = wr_n_q;
      oe_d = oe_q;
      unique case (st_q)
         brwc_pkg::BRWC_IDLE: begin
            if (req_valid_i) begin
               cur_d = req_i;
               cnt_d = {3'h0, ph.ab};
               wcnt_d = 8'h00;
               cs_n_d = 1'b0;
               oe_d = req_i.write;
               st_d = brwc_pkg::BRWC_AB;
            end
         end
         brwc_pkg::BRWC_AB: begin
            if (cnt_q > 5'h01) begin
               cnt_d = cnt_q - 5'h01;
            end else begin
               cnt_d = {3'h0, ph.c};
               st_d = brwc_pkg::BRWC_C;
            end
         end
         brwc_pkg::BRWC_C: begin
            if (cnt_q != 5'h00) begin
               cnt_d = cnt_q - 5'h01;
            end else begin
               cnt_d = {4'h0, ph.d};
               st_d = brwc_pkg::BRWC_D;
            end
         end
         brwc_pkg::BRWC_D: begin
            if (cnt_q != 5'h00) begin
               cnt_d = cnt_q - 5'h01;
            end else begin
               cnt_d = ph.e;
               rd_n_d = cur_q.write;
               wr_n_d = !cur_q.write;
               st_d = brwc_pkg::BRWC_E;
            end
         end
         brwc_pkg::BRWC_E: begin
            // Zero field means 32 access cycles
            if (cnt_q != 5'h01) begin
               cnt_d = cnt_q - 5'h01;
            end else if (rdy_en && !rdy_act) begin
               wcnt_d = wcnt_q + 8'h01;
            end else begin
               if (!cur_q.write) begin
                  rdata_d = data_i;
               end
               rd_n_d = 1'b1;
               wr_n_d = 1'b1;
               cnt_d = {3'h0, ph.f};
               st_d = brwc_pkg::BRWC_F;
            end
         end
         brwc_pkg::BRWC_F: begin
            if (cnt_q != 5'h00) begin
               cnt_d = cnt_q - 5'h01;
            end else begin
               cs_n_d = 1'b1;
               oe_d = 1'b0;
               done_d = 1'b1;
               st_d = brwc_pkg::BRWC_IDLE;
            end
         end
         default: st_d = brwc_pkg::BRWC_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= brwc_pkg::BRWC_IDLE;
         cnt_q <= 5'h00;
         wcnt_q <= 8'h00;
         cur_q <= '0;
         rdata_q <= 16'h0000;
         done_q <= 1'b0;
         cs_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wcnt_q <= wcnt_d;
         cur_q <= cur_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         cs_n_q <= cs_n_d;
         rd_n_q <= rd_n_d;
         wr_n_q <= wr_n_d;
         oe_q <= oe_d;
      end
   end

   assign req_ready_o = st_q == brwc_pkg::BRWC_IDLE;
   assign done_o = done_q;
   assign rdata_o = rdata_q;
   // Reference clock is the system clock itself
   assign bus_reference_clock_out_o = clk_i;
   assign cs_n_o = cs_n_q;
   assign rd_n_o = rd_n_q;
   assign wr_n_o = wr_n_q;
   assign addr_o = cur_q.addr;
   assign data_o = cur_q.wdata;
   assign data_oe_o = oe_q;
endmodule

// ===== rtl/brwc_pkg.sv
// Purpose: Constants and carrier types for the bus READY wait control block
// Assumes: 100 MHz system clock, bus reference clock is a copy of it
// Notes: Phase ranges follow the programmable bus cycle phase table
package brwc_pkg;
   // Wishbone register map
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_TIME = 4'h4;
   localparam logic [3:0] ADR_STAT = 4'h8;
   // Control register fields
   localparam int CTRL_POL_BIT = 0;
   localparam int CTRL_ASYNC_BIT = 1;
   localparam int CTRL_RDYEN_BIT = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Timing register fields
   localparam int TM_AB_LSB = 0;
   localparam int TM_C_LSB = 4;
   localparam int TM_D_LSB = 8;
   localparam int TM_E_LSB = 12;
   localparam int TM_F_LSB = 20;
   localparam logic [31:0] TIME_RESET = 32'h0000_0001;
   localparam logic [31:0] TIME_MASK = 32'h0031_F133;
   // Status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_WAIT_LSB = 8;
   // Synchroniser depth of the asynchronous ready path
   localparam int ASYNC_LAT = 2;

   typedef enum logic [2:0] {
      BRWC_IDLE = 3'b000,
      BRWC_AB = 3'b001,
      BRWC_C = 3'b011,
      BRWC_D = 3'b010,
      BRWC_E = 3'b110,
      BRWC_F = 3'b111
   } brwc_state_t;

   typedef struct packed {
      logic [1:0] ab;
      logic [1:0] c;
      logic d;
      logic [4:0] e;
      logic [1:0] f;
   } brwc_phase_t;

   typedef struct packed {
      logic [23:0] addr;
      logic write;
      logic [15:0] wdata;
   } brwc_req_t;
endpackage

// ===== dv/brwc_asserts.sv
// Purpose: Port assertions for brwc_top
// Assumes: One clock, sync reset
// Notes: Bound into every brwc_top
`timescale 1ns/1ps
module brwc_asserts (
   // Clock, reset, Wishbone
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   // Request and bus pins
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic done_o,
   input wire logic cs_n_o,
   input wire logic rd_n_o,
   input wire logic wr_n_o,
   input wire logic [23:0] addr_o,
   input wire logic data_oe_o,
   input wire logic [15:0] data_i,
   input wire logic [15:0] rdata_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_once: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("ack is not one pulse");
   chk_req_start: assert property (req_valid_i && req_ready_o |=> !cs_n_o)
      else $error("cycle did not start");
   chk_busy_refuse: assert property (!cs_n_o |-> !req_ready_o)
      else $error("ready while busy");
   chk_rd_window: assert property (!rd_n_o |-> !cs_n_o && wr_n_o)
      else $error("read strobe outside cycle");
   chk_wr_drive: assert property (!wr_n_o |-> data_oe_o && !cs_n_o)
      else $error("write strobe without drive");
   chk_hold_phase: assert property ($rose(rd_n_o) || $rose(wr_n_o) |-> !cs_n_o)
      else $error("no hold phase");
   chk_rd_capture: assert property ($rose(rd_n_o) |-> rdata_o == $past(data_i))
      else $error("read data not taken at strobe rise");
   chk_addr_hold: assert property (!cs_n_o && !$past(cs_n_o) |-> $stable(addr_o))
      else $error("address moved in cycle");
   chk_done_end: assert property (done_o |-> $rose(cs_n_o))
      else $error("done without cycle end");
endmodule
bind brwc_top brwc_asserts i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .req_valid_i,
   .req_ready_o, .done_o, .cs_n_o, .rd_n_o, .wr_n_o, .addr_o, .data_oe_o, .data_i, .rdata_o);

// ===== dv/brwc_mem.sv
// Purpose: External memory answering with READY
// Assumes: Strobes registered to clk_i
// Notes: Released data bus shows the inverse value
`timescale 1ns/1ps
module brwc_mem (
   // Bus side
   input wire logic clk_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [23:0] addr_i,
   // Bench control
   input wire logic [3:0] dly_i,
   input wire logic act_hi_i,
   // Answers
   output logic ready_o,
   output logic [15:0] data_o
);
   logic [3:0] cnt_q;
   logic rdy;
   always_ff @(posedge clk_i) cnt_q <= (rd_n_i && wr_n_i) ? 4'h0 : cnt_q + 4'h1;
   // Level held to strobe rise, dropped with it
   assign rdy = !(rd_n_i && wr_n_i) && cnt_q >= dly_i;
   assign ready_o = act_hi_i ? rdy : !rdy;
   assign data_o = (addr_i[15:0] ^ 16'hA5A5) ^ {16{rd_n_i}};
endmodule

// ===== dv/brwc_top_tb_top.sv
// Purpose: Self-checking bench for brwc_top
// Assumes: brwc_mem stands on the external bus
// Notes: Phase lengths checked against a base cycle
`timescale 1ns/1ps
module brwc_top_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, req_valid_i = 1'b0, act_hi = 1'b1;
   logic ack_o, req_ready_o, done_o, cs_n_o, rd_n_o, wr_n_o, ready_i;
   logic [3:0] adr_i = 4'h0, dly = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic [15:0] rdata_o, data_o, data_i;
   logic [23:0] addr_o;
   brwc_pkg::brwc_req_t req_i = '0;
   int fails = 0, checked = 0, cyc_n = 0, n, n0;
   logic [31:0] tm [6] = '{32'h1002, 32'h1011, 32'h1031, 32'h1101, 32'h30_1001, 32'h3001};
   int add [6] = '{1, 1, 3, 1, 3, 1};
   brwc_top i_brwc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i(4'hF), .dat_i,
      .dat_o, .ack_o, .req_valid_i, .req_i, .req_ready_o, .done_o, .rdata_o,
      .bus_reference_clock_out_o(), .cs_n_o, .rd_n_o, .wr_n_o, .addr_o, .data_o,
      .data_oe_o(), .data_i, .ready_i);
   brwc_mem i_brwc_mem (.clk_i, .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .addr_i(addr_o),
      .dly_i(dly), .act_hi_i(act_hi), .ready_o(ready_i), .data_o(data_i));
   always #5 clk_i = ~clk_i;
   // Tests need under a thousand cycles
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 5000) begin
         fails++;
         final_report;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      if (ack_o !== 1'b1) begin
         fails++;
         $display("[ERR] %0t no bus acknowledge", $time);
      end
      q = dat_o;
      {cyc_i, stb_i} <= 2'b00;
   endtask
   task automatic go(input logic w, input logic [23:0] a);
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_i <= '{addr: a, write: w, wdata: a[15:0] ^ 16'h3C3C};
      @(posedge clk_i);
      req_valid_i <= 1'b0;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (done_o !== 1'b1 && n < 300);
      if (done_o !== 1'b1) begin
         fails++;
         $display("[ERR] %0t bus cycle never ended", $time);
      end
   endtask
   task automatic final_report;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, brwc_pkg::ADR_CTRL, 0);
      chk(q, brwc_pkg::CTRL_RESET);
      wb(0, brwc_pkg::ADR_TIME, 0);
      chk(q, brwc_pkg::TIME_RESET);
      wb(0, 4'hC, 0);
      chk(q, 32'h0);
      wb(1, brwc_pkg::ADR_TIME, 32'hFFFF_FFFF);
      wb(0, brwc_pkg::ADR_TIME, 0);
      chk(q, brwc_pkg::TIME_MASK);
      $display("registers done");
      wb(1, brwc_pkg::ADR_CTRL, 32'h5);
      wb(1, brwc_pkg::ADR_TIME, 32'h1001);
      go(0, 24'h012345);
      n0 = n;
      chk(rdata_o, 16'h2345 ^ 16'hA5A5);
      // Each phase field adds its own cycles only
      for (int i = 0; i < 6; i++) begin
         wb(1, brwc_pkg::ADR_TIME, tm[i]);
         go(0, 24'h000100 + 24'(i));
         chk(n, n0 + add[i]);
      end
      $display("phases done");
      wb(1, brwc_pkg::ADR_TIME, 32'h1001);
      dly <= 4'h2;
      go(0, 24'h000200);
      chk(n, n0 + 2);
      wb(0, brwc_pkg::ADR_STAT, 0);
      chk(q, 32'h0000_0300);
      act_hi <= 1'b0;
      dly <= 4'h0;
      wb(1, brwc_pkg::ADR_CTRL, 32'h4);
      go(0, 24'h000300);
      chk(n, n0);
      act_hi <= 1'b1;
      wb(1, brwc_pkg::ADR_CTRL, 32'h7);
      go(0, 24'h000400);
      chk(n, n0 + 1);
      $display("ready modes done");
      go(1, 24'hABCDEF);
      chk(data_o, 16'hCDEF ^ 16'h3C3C);
      chk(addr_o, 24'hABCDEF);
      wb(0, brwc_pkg::ADR_STAT, 0);
      chk(q[0], 1'b0);
      $display("write done");
      final_report;
   end
endmodule
